//--- hdl/cvss_top.sv
// Function
// R1: at power-up the block checks non-volatile storage for about 5 ms and loads any stored settings.
// R2: a restore command from software repeats the storage check and load.
// R3: after the storage check every configuration pin is sampled and its setting loaded; the code samples the pins only when storage held no settings.
// R4: during storage check and pin load, enable and bus traffic are ignored.
// R5: after initialisation the block is ready, takes bus commands and answers enable.
// R6: once enabled the block waits at least 2 ms before the output may ramp.
// R7: a configured delay below 2 ms becomes 2 ms, a longer one is waited in full.
// R8: the soft-start pin can select a delay longer than the minimum.
// R9: after the delay the output ramps to target over the pin-selected ramp time.
// R10: enable tied active still waits for the full initialisation before ramping.
// R11: the host keeps an external clock stable before raising enable.
// R12: the three-state voltage pin gives 1.2 V low, 1.5 V open, 3.3 V high.
// R13: a select resistor maps to one of 31 targets from 0.6 V to 5.0 V.
// R14: software may write any target from 0.6 V to 5.0 V, overriding the pin.
// R15: configuration pins are sampled only at power-up or on restore.
// R16: enable dropped during the pre-ramp delay returns the block to ready.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cvss_top #(
  parameter int MS_CYCLES = cvss_pkg::MS_CYCLES_DFLT
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        en_in,
  input  wire logic        nvm_present,
  input  wire logic [8:0]  nvm_vout,
  input  wire logic [7:0]  nvm_delay_ms,
  input  wire logic [7:0]  nvm_ramp_ms,
  input  wire logic [1:0]  output_voltage_select_pin,
  input  wire logic [4:0]  voltage_select_resistor,
  input  wire logic [1:0]  ss_pin,
  input  wire logic [4:0]  ss_resistor,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             dev_ready,
  output logic             delay_active,
  output logic             ramp_active,
  output logic             output_on,
  output logic      [8:0]  vout_target,
  output logic      [7:0]  ramp_ms
);
  cvss_tmr_if tif ();

  cvss_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_tmr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .t        (tif.tmr)
  );

  // resistor index to target, 10 mV units
  function automatic logic [8:0] vres_decode(input logic [4:0] idx);
    logic [8:0] v;
    v = cvss_pkg::VOUT_MAX;
    unique case (idx)
      5'h00: v = 9'h03c;
      5'h01: v = 9'h046;
      5'h02: v = 9'h04b;
      5'h03: v = 9'h050;
      5'h04: v = 9'h05a;
      5'h05: v = 9'h064;
      5'h06: v = 9'h06e;
      5'h07: v = 9'h078;
      5'h08: v = 9'h07d;
      5'h09: v = 9'h082;
      5'h0a: v = 9'h08c;
      5'h0b: v = 9'h096;
      5'h0c: v = 9'h0a0;
      5'h0d: v = 9'h0aa;
      5'h0e: v = 9'h0b4;
      5'h0f: v = 9'h0be;
      5'h1e: v = cvss_pkg::VOUT_MAX;
      5'h1f: v = cvss_pkg::VOUT_MAX;
      default: v = 9'h0c8 + 9'd10 * {4'h0, idx - 5'h10};
    endcase
    return v;
  endfunction

  // soft-start resistor index to delay: 5, 10, 20 ms repeating
  function automatic logic [7:0] ssd_decode(input logic [4:0] idx);
    logic [7:0] d;
    d = cvss_pkg::SS_OPEN_MS;
    unique case (idx % 5'd3)
      5'd0:    d = cvss_pkg::SS_OPEN_MS;
      5'd1:    d = cvss_pkg::SS_HIGH_MS;
      default: d = cvss_pkg::SS_20_MS;
    endcase
    return d;
  endfunction

  // soft-start resistor index to ramp, one value per group of three
  function automatic logic [7:0] ssr_decode(input logic [4:0] idx);
    logic [7:0] r;
    r = cvss_pkg::SS_OPEN_MS;
    unique case (idx / 5'd3)
      5'd0, 5'd3, 5'd7: r = cvss_pkg::SS_OPEN_MS;
      5'd1, 5'd4, 5'd8: r = cvss_pkg::SS_HIGH_MS;
      5'd2, 5'd6:       r = cvss_pkg::SS_LOW_MS;
      default:          r = cvss_pkg::SS_20_MS;
    endcase
    return r;
  endfunction

  cvss_pkg::cvss_state_t state_ff;
  cvss_pkg::cvss_state_t nxt_state;
  logic [8:0]  vout_ff;
  logic [8:0]  nxt_vout;
  logic [7:0]  dly_ff;
  logic [7:0]  nxt_dly;
  logic [7:0]  ramp_ff;
  logic [7:0]  nxt_ramp;
  logic        nvm_hit_ff;
  logic        nxt_nvm_hit;
  logic        swv_ff;
  logic        nxt_swv;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        rdy_ff;
  logic        nxt_rdy;
  logic        dact_ff;
  logic        nxt_dact;
  logic        ract_ff;
  logic        nxt_ract;
  logic        on_ff;
  logic        nxt_on;
  logic        in_init;
  logic        bus_wr;
  logic        restore;
  logic [7:0]  eff_dly;
  logic [8:0]  wr_vout;
  logic [2:0]  state_code;

  assign in_init = (state_ff == cvss_pkg::CVSS_BOOT) ||
                   (state_ff == cvss_pkg::CVSS_NVM)  ||
                   (state_ff == cvss_pkg::CVSS_PINS);
  assign bus_wr  = reg_wr && !in_init;                               // [R4]
  assign restore = bus_wr && (reg_addr == cvss_pkg::OFS_CTRL) &&
                   reg_wdata[cvss_pkg::CTRL_RESTORE];                // [R2]
  assign eff_dly = (dly_ff < cvss_pkg::MIN_DELAY_MS) ?
                   cvss_pkg::MIN_DELAY_MS : dly_ff;                  // [R7]
  assign wr_vout = reg_wdata[8:0];
  assign state_code = state_ff;

  // sequencer
  always_comb begin
    nxt_state  = state_ff;
    tif.start  = 1'b0;
    tif.abort  = 1'b0;
    tif.units  = 8'h00;
    unique case (state_ff)
      cvss_pkg::CVSS_BOOT: begin
        tif.start = 1'b1;
        tif.units = cvss_pkg::INIT_MS;                               // [R1]
        nxt_state = cvss_pkg::CVSS_NVM;
      end
      cvss_pkg::CVSS_NVM: begin
        if (tif.done) begin
          nxt_state = cvss_pkg::CVSS_PINS;                           // [R10]
        end
      end
      cvss_pkg::CVSS_PINS: begin
        nxt_state = cvss_pkg::CVSS_READY;                            // [R5]
      end
      cvss_pkg::CVSS_READY: begin
        if (en_in) begin
          tif.start = 1'b1;
          tif.units = eff_dly;                                       // [R6]
          nxt_state = cvss_pkg::CVSS_DELAY;
        end
      end
      cvss_pkg::CVSS_DELAY: begin
        if (!en_in) begin
          tif.abort = 1'b1;
          nxt_state = cvss_pkg::CVSS_READY;                          // [R16]
        end else if (tif.done) begin
          tif.start = 1'b1;
          tif.units = ramp_ff;                                       // [R9]
          nxt_state = cvss_pkg::CVSS_RAMP;
        end
      end
      cvss_pkg::CVSS_RAMP: begin
        if (!en_in) begin
          tif.abort = 1'b1;
          nxt_state = cvss_pkg::CVSS_READY;
        end else if (tif.done) begin
          nxt_state = cvss_pkg::CVSS_ON;
        end
      end
      cvss_pkg::CVSS_ON: begin
        if (!en_in) begin
          nxt_state = cvss_pkg::CVSS_READY;
        end
      end
      default: nxt_state = cvss_pkg::CVSS_BOOT;
    endcase
    if (restore) begin
      tif.abort = 1'b0;
      tif.start = 1'b1;
      tif.units = cvss_pkg::INIT_MS;
      nxt_state = cvss_pkg::CVSS_NVM;                                // [R2]
    end
  end

  // settings: storage, pins, software
  always_comb begin
    nxt_vout    = vout_ff;
    nxt_dly     = dly_ff;
    nxt_ramp    = ramp_ff;
    nxt_nvm_hit = nvm_hit_ff;
    nxt_swv     = swv_ff;
    if (state_ff == cvss_pkg::CVSS_NVM && tif.done) begin
      nxt_nvm_hit = nvm_present;
      nxt_swv     = 1'b0;
      if (nvm_present) begin
        nxt_vout = nvm_vout;                                         // [R1]
        nxt_dly  = nvm_delay_ms;
        nxt_ramp = nvm_ramp_ms;
      end
    end
    if (state_ff == cvss_pkg::CVSS_PINS && !nvm_hit_ff) begin
      unique case (output_voltage_select_pin)                        // [R3]
        cvss_pkg::PIN_LOW:  nxt_vout = cvss_pkg::VOUT_LOW;           // [R12]
        cvss_pkg::PIN_OPEN: nxt_vout = cvss_pkg::VOUT_OPEN;
        cvss_pkg::PIN_HIGH: nxt_vout = cvss_pkg::VOUT_HIGH;
        cvss_pkg::PIN_RES:
          nxt_vout = vres_decode(voltage_select_resistor);           // [R13]
      endcase
      unique case (ss_pin)                                           // [R8]
        cvss_pkg::PIN_LOW: begin
          nxt_dly  = cvss_pkg::SS_LOW_MS;
          nxt_ramp = cvss_pkg::SS_LOW_MS;
        end
        cvss_pkg::PIN_OPEN: begin
          nxt_dly  = cvss_pkg::SS_OPEN_MS;
          nxt_ramp = cvss_pkg::SS_OPEN_MS;
        end
        cvss_pkg::PIN_HIGH: begin
          nxt_dly  = cvss_pkg::SS_HIGH_MS;
          nxt_ramp = cvss_pkg::SS_HIGH_MS;
        end
        cvss_pkg::PIN_RES: begin
          nxt_dly  = ssd_decode(ss_resistor);
          nxt_ramp = ssr_decode(ss_resistor);                        // [R9]
        end
      endcase
    end
    if (bus_wr && !restore) begin
      unique case (reg_addr)
        cvss_pkg::OFS_VOUT: begin
          if (wr_vout >= cvss_pkg::VOUT_MIN &&
              wr_vout <= cvss_pkg::VOUT_MAX) begin
            nxt_vout = wr_vout;                                      // [R14]
            nxt_swv  = 1'b1;
          end
        end
        cvss_pkg::OFS_SS_DELAY: nxt_dly  = reg_wdata[7:0];           // [R7]
        cvss_pkg::OFS_SS_RAMP:  nxt_ramp = reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // register reads and status outputs
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd && !in_init) begin                                    // [R4]
      unique case (reg_addr)
        cvss_pkg::OFS_VOUT:     nxt_rdata = {23'h000000, vout_ff};
        cvss_pkg::OFS_SS_DELAY: nxt_rdata = {24'h000000, dly_ff};
        cvss_pkg::OFS_SS_RAMP:  nxt_rdata = {24'h000000, ramp_ff};
        cvss_pkg::OFS_STATUS: begin
          nxt_rdata[2:0]                    = state_code;
          nxt_rdata[cvss_pkg::ST_READY_BIT] = rdy_ff;
          nxt_rdata[cvss_pkg::ST_SWV_BIT]   = swv_ff;
          nxt_rdata[cvss_pkg::ST_NVM_BIT]   = nvm_hit_ff;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_rdy  = !(nxt_state == cvss_pkg::CVSS_BOOT ||
                 nxt_state == cvss_pkg::CVSS_NVM  ||
                 nxt_state == cvss_pkg::CVSS_PINS);                  // [R5]
    nxt_dact = (nxt_state == cvss_pkg::CVSS_DELAY);
    nxt_ract = (nxt_state == cvss_pkg::CVSS_RAMP);
    nxt_on   = (nxt_state == cvss_pkg::CVSS_ON);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= cvss_pkg::CVSS_BOOT;
      vout_ff    <= cvss_pkg::VOUT_RST;
      dly_ff     <= cvss_pkg::SS_RST_MS;
      ramp_ff    <= cvss_pkg::SS_RST_MS;
      nvm_hit_ff <= 1'b0;
      swv_ff     <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rdy_ff     <= 1'b0;
      dact_ff    <= 1'b0;
      ract_ff    <= 1'b0;
      on_ff      <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      vout_ff    <= nxt_vout;                                        // [R15]
      dly_ff     <= nxt_dly;
      ramp_ff    <= nxt_ramp;
      nvm_hit_ff <= nxt_nvm_hit;
      swv_ff     <= nxt_swv;
      rdata_ff   <= nxt_rdata;
      rdy_ff     <= nxt_rdy;
      dact_ff    <= nxt_dact;
      ract_ff    <= nxt_ract;
      on_ff      <= nxt_on;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign dev_ready    = rdy_ff;
  assign delay_active = dact_ff;
  assign ramp_active  = ract_ff;
  assign output_on    = on_ff;
  assign vout_target  = vout_ff;
  assign ramp_ms      = ramp_ff;
endmodule
`default_nettype wire

//--- hdl/cvss_pkg.sv
package cvss_pkg;
  // clock and time base
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          MS_NS          = 1000000;
  localparam int          MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int          PRE_W          = 17;
  // start-up times in ms
  localparam logic [7:0]  INIT_MS        = 8'h05;
  localparam logic [7:0]  MIN_DELAY_MS   = 8'h02;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_VOUT       = 8'h04;
  localparam logic [7:0]  OFS_SS_DELAY   = 8'h08;
  localparam logic [7:0]  OFS_SS_RAMP    = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;
  // field positions
  localparam int          CTRL_RESTORE   = 0;
  localparam int          ST_READY_BIT   = 3;
  localparam int          ST_SWV_BIT     = 4;
  localparam int          ST_NVM_BIT     = 5;
  // three-state pin encodings
  localparam logic [1:0]  PIN_LOW        = 2'h0;
  localparam logic [1:0]  PIN_OPEN       = 2'h1;
  localparam logic [1:0]  PIN_HIGH       = 2'h2;
  localparam logic [1:0]  PIN_RES        = 2'h3;
  // voltages in 10 mV units
  localparam logic [8:0]  VOUT_MIN       = 9'h03c;
  localparam logic [8:0]  VOUT_MAX       = 9'h1f4;
  localparam logic [8:0]  VOUT_LOW       = 9'h078;
  localparam logic [8:0]  VOUT_OPEN      = 9'h096;
  localparam logic [8:0]  VOUT_HIGH      = 9'h14a;
  // soft-start pin-strap times in ms
  localparam logic [7:0]  SS_LOW_MS      = 8'h02;
  localparam logic [7:0]  SS_OPEN_MS     = 8'h05;
  localparam logic [7:0]  SS_HIGH_MS     = 8'h0a;
  localparam logic [7:0]  SS_20_MS       = 8'h14;
  // reset values and last resistor step
  localparam logic [8:0]  VOUT_RST       = VOUT_OPEN;
  localparam logic [7:0]  SS_RST_MS      = SS_OPEN_MS;
  localparam logic [4:0]  RES_LAST       = 5'h1e;

  typedef enum logic [2:0] {
    CVSS_BOOT, CVSS_NVM, CVSS_PINS, CVSS_READY,
    CVSS_DELAY, CVSS_RAMP, CVSS_ON
  } cvss_state_t;
endpackage

//--- hdl/cvss_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cvss_tmr_if;
  logic       start;
  logic       abort;
  logic [7:0] units;
  logic       done;
  logic       busy;
  modport ctl (output start, output abort, output units,
               input done, input busy);
  modport tmr (input start, input abort, input units,
               output done, output busy);
endinterface
`default_nettype wire

//--- hdl/cvss_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
module cvss_ms_timer #(
  parameter int MS_CYCLES = cvss_pkg::MS_CYCLES_DFLT
) (
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  cvss_tmr_if.tmr    t
);
  localparam logic [cvss_pkg::PRE_W-1:0] PRE_LAST =
    cvss_pkg::PRE_W'(MS_CYCLES - 1);

  logic [cvss_pkg::PRE_W-1:0] pre_ff;
  logic [cvss_pkg::PRE_W-1:0] nxt_pre;
  logic [7:0]                 left_ff;
  logic [7:0]                 nxt_left;
  logic                       busy_ff;
  logic                       nxt_busy;
  logic                       done_ff;
  logic                       nxt_done;

  // counts whole milliseconds; zero units finish at once
  always_comb begin
    nxt_pre  = pre_ff;
    nxt_left = left_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (t.abort) begin
      nxt_busy = 1'b0;
      nxt_pre  = '0;
    end else if (t.start) begin
      nxt_busy = 1'b1;
      nxt_left = t.units;
      nxt_pre  = '0;
    end else if (busy_ff) begin
      if (left_ff == 8'h00) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else if (pre_ff == PRE_LAST) begin
        nxt_pre  = '0;
        nxt_left = left_ff - 8'h01;
      end else begin
        nxt_pre = pre_ff + cvss_pkg::PRE_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff  <= '0;
      left_ff <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      pre_ff  <= nxt_pre;
      left_ff <= nxt_left;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign t.done = done_ff;
  assign t.busy = busy_ff;
endmodule
`default_nettype wire

//--- tb/cvss_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cvss_top_chk #(
  parameter int MS_CYCLES = 10
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        en_in,
  input wire logic        nvm_present,
  input wire logic [8:0]  nvm_vout,
  input wire logic [7:0]  nvm_delay_ms,
  input wire logic [7:0]  nvm_ramp_ms,
  input wire logic [1:0]  output_voltage_select_pin,
  input wire logic [4:0]  voltage_select_resistor,
  input wire logic [1:0]  ss_pin,
  input wire logic [4:0]  ss_resistor,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        dev_ready,
  input wire logic        delay_active,
  input wire logic        ramp_active,
  input wire logic        output_on,
  input wire logic [8:0]  vout_target,
  input wire logic [7:0]  ramp_ms
);
  int init_ff;
  int nxt_init;
  int dly_ff;
  int nxt_dly;
  // cycles spent initialising, cycles spent in pre-ramp delay
  always_comb begin
    nxt_init = dev_ready ? 0 : init_ff + 1;
    nxt_dly  = delay_active ? dly_ff + 1 : 0;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_ff <= 0;
      dly_ff  <= 0;
    end else begin
      init_ff <= nxt_init;
      dly_ff  <= nxt_dly;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_init_quiet: assert property (
    !dev_ready |-> !(delay_active || ramp_active || output_on))
    else $error("sequence active while initialising");
  a_init_len: assert property (
    $rose(dev_ready) |-> init_ff >= 5 * MS_CYCLES)
    else $error("initialisation too short");
  a_rd_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_rd_init: assert property (
    !dev_ready && reg_rd |=> reg_rdata == 32'h0)
    else $error("read answered during init");
  a_en_delay: assert property (
    dev_ready && en_in && !(delay_active || ramp_active || output_on)
    && !reg_wr |=> delay_active) else $error("enable not taken");
  a_drop_en: assert property (
    (delay_active || ramp_active || output_on) && !en_in |=>
    !(delay_active || ramp_active || output_on))
    else $error("enable drop ignored");
  a_min_delay: assert property (
    ramp_active && $past(delay_active) |-> dly_ff >= 2 * MS_CYCLES)
    else $error("pre-ramp delay too short");
  a_cfg_hold: assert property (
    dev_ready && $past(dev_ready) && !$past(reg_wr) |->
    $stable(vout_target) && $stable(ramp_ms))
    else $error("configuration changed without write");
  a_vout_range: assert property (
    dev_ready |-> vout_target >= 9'h03c && vout_target <= 9'h1f4)
    else $error("target out of range");
endmodule
bind cvss_top cvss_top_chk #(.MS_CYCLES(MS_CYCLES)) cvss_top_chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .en_in(en_in),
  .nvm_present(nvm_present), .nvm_vout(nvm_vout),
  .nvm_delay_ms(nvm_delay_ms), .nvm_ramp_ms(nvm_ramp_ms),
  .output_voltage_select_pin(output_voltage_select_pin),
  .voltage_select_resistor(voltage_select_resistor),
  .ss_pin(ss_pin), .ss_resistor(ss_resistor), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dev_ready(dev_ready),
  .delay_active(delay_active), .ramp_active(ramp_active),
  .output_on(output_on), .vout_target(vout_target), .ramp_ms(ramp_ms));
`default_nettype wire

//--- tb/cvss_host.sv
`timescale 1ns/10ps
`default_nettype none
module cvss_host (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic en_req,
  output logic      en_in
);
  logic [2:0] settle_ff;
  // enable held off until the clock has settled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_ff <= 3'h0;
      en_in     <= 1'b0;
    end else begin
      if (settle_ff != 3'h7) settle_ff <= settle_ff + 3'h1;
      en_in <= en_req && (settle_ff == 3'h7);
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_cvss_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cvss_top;
  localparam int MS  = 10;
  localparam int LIM = 3000;
  logic        core_clk, rst_n, en_req, en_in, nvm_present, reg_wr, reg_rd;
  logic        dev_ready, delay_active, ramp_active, output_on;
  logic [8:0]  nvm_vout, vout_target;
  logic [7:0]  nvm_delay_ms, nvm_ramp_ms, reg_addr, ramp_ms;
  logic [1:0]  vsel, ss_pin;
  logic [4:0]  vres, ss_res;
  logic [31:0] reg_wdata, reg_rdata;
  int          n_errors = 0, num_checks = 0, n, i;
  logic [1:0]  t_pin [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0};
  logic [4:0]  t_res [7] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h7, 5'h1e, 5'h0};
  logic [8:0]  t_exp [7] = '{9'h078, 9'h096, 9'h14a, 9'h03c, 9'h078,
                             9'h1f4, 9'h0c8};
  logic [8:0]  w_val [4] = '{9'h1f4, 9'h1f5, 9'h03b, 9'h03c};
  logic [8:0]  w_exp [4] = '{9'h1f4, 9'h1f4, 9'h1f4, 9'h03c};
  cvss_top #(.MS_CYCLES(MS)) cvss_top_inst (
    .core_clk(core_clk), .rst_n(rst_n), .en_in(en_in),
    .nvm_present(nvm_present), .nvm_vout(nvm_vout),
    .nvm_delay_ms(nvm_delay_ms), .nvm_ramp_ms(nvm_ramp_ms),
    .output_voltage_select_pin(vsel), .voltage_select_resistor(vres),
    .ss_pin(ss_pin), .ss_resistor(ss_res), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dev_ready(dev_ready),
    .delay_active(delay_active), .ramp_active(ramp_active),
    .output_on(output_on), .vout_target(vout_target), .ramp_ms(ramp_ms));
  cvss_host cvss_host_inst (.core_clk(core_clk), .rst_n(rst_n),
    .en_req(en_req), .en_in(en_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic pick(input int s);
    case (s)
      0: pick = dev_ready;
      1: pick = delay_active;
      default: pick = ramp_active;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  // counts cycles in n until the picked output reaches lvl
  task automatic wait_lvl(input int s, input logic lvl);
    n = 0;
    #1;
    while (pick(s) !== lvl) begin
      if (n == LIM) begin
        n_errors++;
        tally_and_finish();
      end
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge core_clk);
    #1;
  endtask
  task automatic run_seq(input int d, input int r);
    en_req <= 1'b1;
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    rng(n, d * MS, d * MS + 3);
    wait_lvl(2, 1'b0);
    rng(n, r * MS, r * MS + 3);
    @(posedge core_clk);
    #1;
    chk(output_on, 1'b1);
    en_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(output_on, 1'b0);
  endtask
  task automatic restore();
    wr(cvss_pkg::OFS_CTRL, 32'h1);
    chk(dev_ready, 1'b0);
    wait_lvl(0, 1'b1);
    rng(n, 5 * MS - 2, 5 * MS + 4);
  endtask
  initial begin
    rst_n = 1'b0;
    en_req = 1'b1;
    nvm_present = 1'b0;
    nvm_vout = 9'h0c8;
    nvm_delay_ms = 8'h03;
    nvm_ramp_ms = 8'h01;
    vsel = 2'h0;
    vres = 5'h0;
    ss_pin = 2'h0;
    ss_res = 5'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #1;
    chk(vout_target, cvss_pkg::VOUT_RST);
    chk(ramp_ms, cvss_pkg::SS_RST_MS);
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(cvss_pkg::OFS_STATUS, 32'h0);
    wr(cvss_pkg::OFS_VOUT, 32'h1f4);
    wait_lvl(0, 1'b1);
    chk(vout_target, cvss_pkg::VOUT_LOW);
    run_seq(2, 2);
    $display("test init done");
    for (i = 0; i < 2; i++) begin
      wr(cvss_pkg::OFS_SS_DELAY, i ? 32'h4 : 32'h1);
      wr(cvss_pkg::OFS_SS_RAMP, i ? 32'h0 : 32'h3);
      run_seq(i ? 4 : 2, i ? 0 : 3);
    end
    $display("test delay done");
    en_req <= 1'b1;
    wait_lvl(1, 1'b1);
    repeat (5) @(posedge core_clk);
    en_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(delay_active | ramp_active, 1'b0);
    rd(cvss_pkg::OFS_STATUS, 32'hb);
    $display("test abort done");
    for (i = 0; i < 4; i++) begin
      wr(cvss_pkg::OFS_VOUT, {23'h0, w_val[i]});
      chk(vout_target, w_exp[i]);
    end
    rd(cvss_pkg::OFS_VOUT, 32'h3c);
    rd(cvss_pkg::OFS_STATUS, 32'h1b);
    vsel <= 2'h2;
    repeat (3) @(posedge core_clk);
    #1;
    chk(vout_target, 9'h03c);
    rd(8'h14, 32'h0);
    rd(cvss_pkg::OFS_SS_DELAY, 32'h4);
    $display("test target done");
    for (i = 0; i < 7; i++) begin
      vsel <= t_pin[i];
      vres <= t_res[i];
      nvm_present <= (i == 6);
      restore();
      chk(vout_target, t_exp[i]);
    end
    run_seq(3, 1);
    rd(cvss_pkg::OFS_STATUS, 32'h2b);
    nvm_present <= 1'b0;
    ss_pin <= 2'h2;
    restore();
    chk(ramp_ms, cvss_pkg::SS_HIGH_MS);
    run_seq(10, 10);
    ss_pin <= 2'h1;
    restore();
    chk(ramp_ms, cvss_pkg::SS_OPEN_MS);
    ss_pin <= 2'h3;
    ss_res <= 5'h07;
    restore();
    chk(ramp_ms, 8'h02);
    rd(cvss_pkg::OFS_SS_DELAY, 32'ha);
    run_seq(10, 2);
    $display("test restore done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
